// >>> core/plc_cmd_if.sv
`timescale 1ns/100ps
`default_nettype none
interface plc_cmd_if;
   logic trigger;
   logic mode;
   logic busy;
   logic wrEn;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport device (input trigger, mode, wrEn, addr, wdata, output busy, rdata);
   modport host (output trigger, mode, wrEn, addr, wdata, input busy, rdata);
endinterface : plc_cmd_if
`default_nettype wire

// >>> core/plc_sock_pkg.sv
`default_nettype none
package plc_sock_pkg;
   localparam int WORD_W = 16;
   localparam int BLOCK_WORDS = 16;
   localparam int MAX_CLIENTS = 8;
   localparam int SER_PORTS = 2;
   // command block word positions
   localparam logic [3:0] W_ERR = 4'h0;
   localparam logic [3:0] W_CODE = 4'h1;
   localparam logic [3:0] W_CONN = 4'h2;
   localparam logic [3:0] W_HANDLER = 4'h3;
   localparam logic [3:0] W_OPT = 4'h4;
   localparam logic [3:0] W_SERVICE = 4'h5;
   localparam logic [3:0] W_ADDR_HI = 4'h6;
   localparam logic [3:0] W_ADDR_LO = 4'h7;
   localparam logic [3:0] W_PORT = 4'h9;
   localparam logic [3:0] W_XFER_ADDR_HI = 4'hA;
   localparam logic [3:0] W_XFER_ADDR_LO = 4'hB;
   localparam logic [3:0] W_XFER_PORT = 4'hC;
   // command codes and fixed values
   localparam logic [15:0] CODE_CREATE = 16'h0003;
   localparam logic [15:0] CODE_WRITE_REMOTE = 16'h0201;
   localparam logic [15:0] CODE_READ_REMOTE = 16'h0202;
   localparam logic [15:0] CONN_FIRST = 16'h4B15; // 19221
   localparam logic [15:0] CONN_LAST = 16'h4B1C; // 19228
   localparam logic [15:0] HANDLER_ID = 16'h0024;
   localparam logic [15:0] SVC_TCP = 16'h0001;
   localparam logic [15:0] SVC_UDP = 16'h0002;
   localparam int OPT_PRIO_BIT = 0;
   localparam int OPT_ADDR_LOC_BIT = 1;
   localparam logic [31:0] ADDR_MIN_BAD = 32'h0000_0000;
   localparam logic [31:0] ADDR_MAX = 32'hDFFF_FFFF;
   localparam logic [15:0] PORT_PEER = 16'h05E1; // 1505
   // error words
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_BAD_CODE = 16'h0001;
   localparam logic [15:0] ERR_BAD_CONN = 16'h0002;
   localparam logic [15:0] ERR_CONN_IN_USE = 16'h0003;
   localparam logic [15:0] ERR_BAD_HANDLER = 16'h0004;
   localparam logic [15:0] ERR_BAD_SERVICE = 16'h0005;
   localparam logic [15:0] ERR_OPT_CONFLICT = 16'h0006;
   localparam logic [15:0] ERR_BAD_ADDR = 16'h0007;
   localparam logic [15:0] ERR_BAD_PORT = 16'h0008;
   localparam logic [15:0] ERR_CONNECT_FAIL = 16'h0009;
   localparam logic [15:0] ERR_NOT_CONNECTED = 16'h240A;
   localparam logic [15:0] ERR_NOT_ACTIVE = 16'h00A6;
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int BLINK_HZ = 2;
   localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
   localparam int LED_STRETCH_US = 5000;
   localparam int LED_STRETCH_CYC = (LED_STRETCH_US * (CLK_HZ / 1_000_000));
endpackage : plc_sock_pkg
`default_nettype wire

// >>> core/plc_socket_device.sv
// Notes on behaviour
// - blink active indicator 2 Hz until parameters load
// - pulse receive indicator on any carrier
// - pulse transmit indicator on any sent frame
// - link indicator on link pulses, else AUI
// - flash collision indicator on each collision
// - light polarity indicator and correct polarity
// - serial port indicators follow receive and transmit
// - redirected port forwards commands, returns responses
// - reset cancels all serial redirection
// - word0 cleared, code 03 creates, word0 reports
// - connection number 19221..19228, unique while open
// - eight client connections open at once
// - word 3 must hold handler 36
// - service 1 connects TCP, 2 stores UDP
// - address-location bit takes address from transfer block
// - TCP with address-location bit is rejected
// - address and port always required at create
// - priority bit schedules client before all else
// - reject address zero or above DFFFFFFF
// - lost TCP gives 240A, closes, then 00A6
// - host puts address words 6-7, port 9
// - host zeroes words 8 and 13-15, and words 10-12 on create
// - trigger and mode with busy handshake
`timescale 1ns/100ps
`default_nettype none
module plc_socket_device
   import plc_sock_pkg::*;
#(
   parameter int BLINK_CYC = plc_sock_pkg::BLINK_HALF_CYC,
   parameter int STRETCH_CYC = plc_sock_pkg::LED_STRETCH_CYC,
   parameter int NPORT = plc_sock_pkg::SER_PORTS
)(
   input wire logic clk_sys,
   input wire logic nrst,
   plc_cmd_if.device cmd,
   input wire logic postDone,
   input wire logic paramsLoaded,
   output logic activeIndicator,
   input wire logic carrierSense,
   output logic receiveActivityIndicator,
   input wire logic txSending,
   output logic transmitActivityIndicator,
   input wire logic linkPulseSeen,
   output logic linkPulseIndicator,
   output logic auiIndicator,
   input wire logic collisionSeen,
   output logic collisionIndicator,
   input wire logic polarityReversed,
   output logic reversedPolarityIndicator,
   input wire logic rxBitRaw,
   output logic rxBitCorrected,
   input wire logic [NPORT-1:0] serRxActive,
   input wire logic [NPORT-1:0] serTxActive,
   output logic [NPORT-1:0] serRxIndicator,
   output logic [NPORT-1:0] serTxIndicator,
   input wire logic redirectWe,
   input wire logic [NPORT-1:0] redirectSel,
   input wire logic redirectOn,
   output logic [NPORT-1:0] redirected,
   input wire logic [NPORT-1:0] serCmdValid,
   output logic [NPORT-1:0] localCmdValid,
   output logic [NPORT-1:0] netFwdValid,
   input wire logic [NPORT-1:0] localRespValid,
   input wire logic [NPORT-1:0] netRespValid,
   output logic [NPORT-1:0] serRespValid,
   output logic tcpConnReq,
   output logic [2:0] tcpConnIdx,
   output logic [31:0] tcpConnAddr,
   output logic [15:0] tcpConnPort,
   input wire logic tcpConnDone,
   input wire logic tcpConnOk,
   input wire logic tcpLost,
   input wire logic [2:0] tcpLostIdx,
   output logic xferValid,
   output logic [2:0] xferIdx,
   output logic [31:0] xferAddr,
   output logic [15:0] xferPort,
   input wire logic [7:0] clientReady,
   input wire logic serverReady,
   output logic schedValid,
   output logic schedServer,
   output logic [2:0] schedClient,
   output logic [7:0] clientOpen
);
   import plc_sock_pkg::*;

   typedef enum logic [3:0] {
      IDLE = 4'b0001,
      EXEC = 4'b0010,
      CONNWAIT = 4'b0100,
      HOLD = 4'b1000
   } dev_state_e;

   function automatic logic addrValid(input logic [31:0] a);
      return (a != ADDR_MIN_BAD) && (a <= ADDR_MAX);
   endfunction : addrValid

   function automatic logic [2:0] firstSet(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--)
         if (v[i]) r = 3'(i);
      return r;
   endfunction : firstSet

   dev_state_e state;
   logic [15:0] blk [BLOCK_WORDS];
   logic [7:0] connTcp, connLoc, connPrio, connLost;
   logic [31:0] connAddr [MAX_CLIENTS];
   logic [15:0] connPort [MAX_CLIENTS];
   logic closePending;
   logic [2:0] closeIdx;
   logic [31:0] blinkCnt;
   logic blinkTick;
   logic [15:0] stretch [3];
   logic [2:0] stretchIn;

   // ---- command block decode
   wire [15:0] code = blk[W_CODE];
   wire [15:0] conn = blk[W_CONN];
   wire [15:0] svc = blk[W_SERVICE];
   wire optLoc = blk[W_OPT][OPT_ADDR_LOC_BIT];
   wire optPrio = blk[W_OPT][OPT_PRIO_BIT];
   wire [2:0] idx = 3'(conn - CONN_FIRST);
   wire [31:0] blkAddr = {blk[W_ADDR_HI], blk[W_ADDR_LO]};
   wire [31:0] blkXAddr = {blk[W_XFER_ADDR_HI], blk[W_XFER_ADDR_LO]};
   wire isCreate = (code == CODE_CREATE);
   wire isXfer = (code == CODE_WRITE_REMOTE) || (code == CODE_READ_REMOTE);
   wire connInRange = (conn >= CONN_FIRST) && (conn <= CONN_LAST);
   wire isTcp = (svc == SVC_TCP);
   wire useXAddr = connLoc[idx] && !connTcp[idx];
   wire [15:0] createErr =
      (blk[W_HANDLER] != HANDLER_ID) ? ERR_BAD_HANDLER :
      !connInRange ? ERR_BAD_CONN :
      clientOpen[idx] ? ERR_CONN_IN_USE :
      (!isTcp && svc != SVC_UDP) ? ERR_BAD_SERVICE :
      (isTcp && optLoc) ? ERR_OPT_CONFLICT :
      !addrValid(blkAddr) ? ERR_BAD_ADDR :
      (blk[W_PORT] == 16'h0000) ? ERR_BAD_PORT : ERR_NONE;
   wire [15:0] xferErr =
      !connInRange ? ERR_BAD_CONN :
      connLost[idx] ? ERR_NOT_CONNECTED :
      !clientOpen[idx] ? ERR_NOT_ACTIVE :
      (connLoc[idx] && !addrValid(blkXAddr)) ? ERR_BAD_ADDR :
      (connLoc[idx] && blk[W_XFER_PORT] == 16'h0000) ? ERR_BAD_PORT : ERR_NONE;
   wire [15:0] execErr = isCreate ? createErr : isXfer ? xferErr : ERR_BAD_CODE;
   wire execOk = (state == EXEC) && (execErr == ERR_NONE);
   wire openNow = (execOk && isCreate && !isTcp) ||
                  (state == CONNWAIT && tcpConnDone && tcpConnOk);
   wire errWe = ((state == EXEC) && (execErr != ERR_NONE)) ||
                (state == CONNWAIT && tcpConnDone && !tcpConnOk);
   wire [15:0] errVal = (state == EXEC) ? execErr : ERR_CONNECT_FAIL;
   wire handDown = !cmd.trigger && !cmd.mode;
   wire closeNow = (state == HOLD) && handDown && closePending;

   assign cmd.busy = (state != IDLE);

   // ---- handshake sequencer
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         state <= IDLE;
      else
         case (state)
            IDLE: if (cmd.trigger && cmd.mode) state <= EXEC;
            EXEC: state <= (execOk && isCreate && isTcp) ? CONNWAIT : HOLD;
            CONNWAIT: if (tcpConnDone) state <= HOLD;
            HOLD: if (handDown) state <= IDLE;
            default: state <= IDLE;
         endcase
   end

   // block words are writable only while idle; word 0 carries the result
   always_ff @(posedge clk_sys)
   begin
      if (cmd.wrEn && state == IDLE)
         blk[cmd.addr] <= cmd.wdata;
      else if (errWe)
         blk[W_ERR] <= errVal;
      cmd.rdata <= blk[cmd.addr];
   end

   // ---- connection table
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         clientOpen <= 8'h00;
         connLost <= 8'h00;
         closePending <= 1'b0;
         closeIdx <= 3'h0;
      end
      else
      begin
         if (tcpLost && clientOpen[tcpLostIdx] && connTcp[tcpLostIdx])
            connLost[tcpLostIdx] <= 1'b1;
         if (closeNow)
         begin
            clientOpen[closeIdx] <= 1'b0;
            connLost[closeIdx] <= 1'b0;
         end
         if (openNow)
            clientOpen[idx] <= 1'b1;
         if (state == EXEC)
         begin
            closePending <= isXfer && connInRange && connLost[idx];
            closeIdx <= idx;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (execOk && isCreate)
      begin
         connTcp[idx] <= isTcp;
         connLoc[idx] <= optLoc;
         connPrio[idx] <= optPrio;
         connAddr[idx] <= blkAddr;
         connPort[idx] <= blk[W_PORT];
      end
   end

   // ---- transfer hand-off and connect request
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         tcpConnReq <= 1'b0;
         tcpConnIdx <= 3'h0;
         tcpConnAddr <= 32'h0000_0000;
         tcpConnPort <= 16'h0000;
         xferValid <= 1'b0;
         xferIdx <= 3'h0;
         xferAddr <= 32'h0000_0000;
         xferPort <= 16'h0000;
      end
      else
      begin
         tcpConnReq <= execOk && isCreate && isTcp;
         xferValid <= execOk && isXfer;
         if (execOk)
         begin
            tcpConnIdx <= idx;
            tcpConnAddr <= blkAddr;
            tcpConnPort <= blk[W_PORT];
            xferIdx <= idx;
            xferAddr <= useXAddr ? blkXAddr : connAddr[idx];
            xferPort <= useXAddr ? blk[W_XFER_PORT] : connPort[idx];
         end
      end
   end

   // ---- scheduler: high-priority clients, then server, then normal clients
   wire [7:0] hiReady = clientReady & clientOpen & connPrio;
   wire [7:0] loReady = clientReady & clientOpen & ~connPrio;
   assign schedValid = (hiReady != 8'h00) || serverReady || (loReady != 8'h00);
   assign schedServer = (hiReady == 8'h00) && serverReady;
   assign schedClient = (hiReady != 8'h00) ? firstSet(hiReady) : firstSet(loReady);

   // ---- serial redirection, cleared by any reset
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         redirected <= '0;
      else if (redirectWe)
         redirected <= redirectOn ? (redirected | redirectSel) : (redirected & ~redirectSel);
   end
   assign netFwdValid = serCmdValid & redirected;
   assign localCmdValid = serCmdValid & ~redirected;
   assign serRespValid = (netRespValid & redirected) | (localRespValid & ~redirected);

   // ---- indicators
   assign blinkTick = (blinkCnt == 32'(BLINK_CYC - 1));
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         blinkCnt <= 32'h0000_0000;
         activeIndicator <= 1'b0;
      end
      else
      begin
         blinkCnt <= blinkTick ? 32'h0000_0000 : blinkCnt + 32'h0000_0001;
         if (!postDone)
            activeIndicator <= 1'b0;
         else if (paramsLoaded)
            activeIndicator <= 1'b1;
         else if (blinkTick)
            activeIndicator <= !activeIndicator;
      end
   end

   // short events are stretched so a single frame still shows
   assign stretchIn = {collisionSeen, txSending, carrierSense};
   for (genvar g = 0; g < 3; g++)
   begin : g_stretch
      always_ff @(posedge clk_sys)
      begin
         if (!nrst)
            stretch[g] <= 16'h0000;
         else if (stretchIn[g])
            stretch[g] <= 16'(STRETCH_CYC);
         else if (stretch[g] != 16'h0000)
            stretch[g] <= stretch[g] - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         receiveActivityIndicator <= 1'b0;
         transmitActivityIndicator <= 1'b0;
         collisionIndicator <= 1'b0;
         linkPulseIndicator <= 1'b0;
         auiIndicator <= 1'b0;
         reversedPolarityIndicator <= 1'b0;
         serRxIndicator <= '0;
         serTxIndicator <= '0;
         rxBitCorrected <= 1'b0;
      end
      else
      begin
         receiveActivityIndicator <= stretch[0] != 16'h0000;
         transmitActivityIndicator <= stretch[1] != 16'h0000;
         collisionIndicator <= stretch[2] != 16'h0000;
         linkPulseIndicator <= linkPulseSeen;
         auiIndicator <= !linkPulseSeen;
         reversedPolarityIndicator <= polarityReversed;
         rxBitCorrected <= rxBitRaw ^ polarityReversed;
         serRxIndicator <= serRxActive;
         serTxIndicator <= serTxActive;
      end
   end
endmodule : plc_socket_device
`default_nettype wire

// >>> core/plc_socket_host.sv
`timescale 1ns/100ps
`default_nettype none
module plc_socket_host
   import plc_sock_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   plc_cmd_if.host cmd,
   input wire logic start,
   input wire logic [15:0] cmdCode,
   input wire logic [15:0] connNum,
   input wire logic [15:0] optionBits,
   input wire logic [15:0] service,
   input wire logic [31:0] remoteAddr,
   input wire logic [15:0] remotePort,
   output logic hostBusy,
   output logic done,
   output logic [15:0] errWord
);
   import plc_sock_pkg::*;

   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_LOAD = 6'b000010,
      H_TRIG = 6'b000100,
      H_DROP = 6'b001000,
      H_READ = 6'b010000,
      H_CAPT = 6'b100000
   } host_state_e;

   host_state_e state;
   logic [3:0] wordIdx;
   logic [15:0] code, conn, opt, svc, port;
   logic [31:0] addr;
   logic isXfer;

   // transfer blocks carry the remote in words 10-12, create blocks in 6, 7 and 9
   function automatic logic [15:0] wordValue(input logic [3:0] i);
      logic [15:0] v;
      v = 16'h0000;
      case (i)
         W_ERR: v = 16'h0000;
         W_CODE: v = code;
         W_CONN: v = conn;
         W_HANDLER: v = isXfer ? 16'h0000 : HANDLER_ID;
         W_OPT: v = isXfer ? 16'h0000 : opt;
         W_SERVICE: v = isXfer ? 16'h0000 : svc;
         W_ADDR_HI: v = isXfer ? 16'h0000 : addr[31:16];
         W_ADDR_LO: v = isXfer ? 16'h0000 : addr[15:0];
         W_PORT: v = isXfer ? 16'h0000 : port;
         W_XFER_ADDR_HI: v = isXfer ? addr[31:16] : 16'h0000;
         W_XFER_ADDR_LO: v = isXfer ? addr[15:0] : 16'h0000;
         W_XFER_PORT: v = isXfer ? port : 16'h0000;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : wordValue

   assign cmd.wrEn = (state == H_LOAD);
   assign cmd.addr = (state == H_LOAD) ? wordIdx : W_ERR;
   assign cmd.wdata = wordValue(wordIdx);
   assign cmd.trigger = (state == H_TRIG);
   assign cmd.mode = (state == H_TRIG);
   assign hostBusy = (state != H_IDLE);

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         state <= H_IDLE;
         wordIdx <= 4'h0;
         done <= 1'b0;
         errWord <= 16'h0000;
      end
      else
      begin
         done <= 1'b0;
         case (state)
            H_IDLE:
               if (start)
               begin
                  wordIdx <= 4'h0;
                  state <= H_LOAD;
               end
            H_LOAD:
            begin
               wordIdx <= wordIdx + 4'h1;
               if (wordIdx == 4'(BLOCK_WORDS - 1))
                  state <= H_TRIG;
            end
            H_TRIG: if (cmd.busy) state <= H_DROP;
            H_DROP: if (!cmd.busy) state <= H_READ;
            H_READ: state <= H_CAPT;
            H_CAPT:
            begin
               errWord <= cmd.rdata;
               done <= 1'b1;
               state <= H_IDLE;
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         code <= 16'h0000;
         conn <= 16'h0000;
         opt <= 16'h0000;
         svc <= 16'h0000;
         addr <= 32'h0000_0000;
         port <= 16'h0000;
         isXfer <= 1'b0;
      end
      else if (state == H_IDLE && start)
      begin
         code <= cmdCode;
         conn <= connNum;
         opt <= optionBits;
         svc <= service;
         addr <= remoteAddr;
         port <= remotePort;
         isXfer <= (cmdCode == CODE_WRITE_REMOTE) || (cmdCode == CODE_READ_REMOTE);
      end
   end
endmodule : plc_socket_host
`default_nettype wire

// >>> sim/plc_socket_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module plc_socket_assertions (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic trigger,
   input wire logic mode,
   input wire logic busy,
   input wire logic wrEn
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   trig_mode_pair_a: assert property (trigger == mode)
      else $error("trigger and mode differ");
   busy_answer_a: assert property (trigger && !busy |=> busy)
      else $error("busy did not answer the trigger");
   busy_cause_a: assert property ($rose(busy) |-> $past(trigger && mode))
      else $error("busy rose without a request");
   busy_hold_a: assert property (busy && trigger |=> busy)
      else $error("busy dropped while trigger still high");
   busy_release_a: assert property ($fell(busy) |-> $past(!trigger && !mode))
      else $error("busy fell before the handshake dropped");
   host_drop_a: assert property ($rose(busy) |-> ##[0:2] !trigger)
      else $error("host kept the trigger after busy");
   trig_wait_a: assert property ($rose(trigger) |-> !busy)
      else $error("trigger raised while busy");
   write_idle_a: assert property (busy |-> !wrEn)
      else $error("block word written while busy");
   block_first_a: assert property ($rose(trigger) |-> $past(wrEn))
      else $error("trigger without a freshly written block");
endmodule : plc_socket_assertions
`default_nettype wire

// >>> sim/plc_socket_command_block_bench.sv
`timescale 1ns/100ps
`default_nettype none
module plc_socket_command_block_bench;
   import plc_sock_pkg::*;
   localparam int STR = 3;
   localparam logic [31:0] A = 32'h0A00_0001;
   logic clk_sys, nrst, start, hostBusy, done, v;
   logic [15:0] cmdCode, connNum, optionBits, service, remotePort, errWord;
   logic [31:0] remoteAddr;
   logic postDone, paramsLoaded, activeIndicator, rxBitRaw, rxBitCorrected;
   logic carrierSense, txSending, collisionSeen, linkPulseSeen, polarityReversed;
   logic receiveActivityIndicator, transmitActivityIndicator, collisionIndicator;
   logic linkPulseIndicator, auiIndicator, reversedPolarityIndicator;
   logic [1:0] serRxActive, serTxActive, serRxIndicator, serTxIndicator, redirectSel, redirected;
   logic [1:0] serCmdValid, localCmdValid, netFwdValid, localRespValid, netRespValid;
   logic [1:0] serRespValid;
   logic redirectWe, redirectOn, tcpConnReq, tcpLost, connOk, xferValid;
   logic tcpConnDone = 1'b0;
   logic tcpConnOk = 1'b0;
   logic [2:0] tcpConnIdx, tcpLostIdx, xferIdx, schedClient;
   logic [31:0] tcpConnAddr, xferAddr, lastXfer;
   logic [15:0] tcpConnPort, xferPort;
   logic serverReady, schedValid, schedServer;
   logic [7:0] clientReady, clientOpen;
   int n_fail, comparisons, i;
   plc_cmd_if bus ();
   plc_socket_host plc_socket_host_i (.clk_sys, .nrst, .cmd(bus), .start, .cmdCode, .connNum,
      .optionBits, .service, .remoteAddr, .remotePort, .hostBusy, .done, .errWord);
   plc_socket_device #(.BLINK_CYC(4), .STRETCH_CYC(STR), .NPORT(2)) plc_socket_device_i (
      .clk_sys, .nrst, .cmd(bus), .postDone, .paramsLoaded, .activeIndicator, .carrierSense,
      .receiveActivityIndicator, .txSending, .transmitActivityIndicator, .linkPulseSeen,
      .linkPulseIndicator, .auiIndicator, .collisionSeen, .collisionIndicator,
      .polarityReversed, .reversedPolarityIndicator, .rxBitRaw, .rxBitCorrected, .serRxActive,
      .serTxActive, .serRxIndicator, .serTxIndicator, .redirectWe, .redirectSel, .redirectOn,
      .redirected, .serCmdValid, .localCmdValid, .netFwdValid, .localRespValid, .netRespValid,
      .serRespValid, .tcpConnReq, .tcpConnIdx, .tcpConnAddr, .tcpConnPort, .tcpConnDone,
      .tcpConnOk, .tcpLost, .tcpLostIdx, .xferValid, .xferIdx, .xferAddr, .xferPort,
      .clientReady, .serverReady, .schedValid, .schedServer, .schedClient, .clientOpen);
   plc_socket_assertions plc_socket_assertions_i (.clk_sys, .nrst, .trigger(bus.trigger),
      .mode(bus.mode), .busy(bus.busy), .wrEn(bus.wrEn));
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // the far end answers a connect half a cycle after the request pulse rises, on the next falling edge
   always @(negedge clk_sys)
   begin
      tcpConnDone <= tcpConnReq;
      tcpConnOk <= connOk;
   end
   always @(posedge clk_sys)
   begin
      if (xferValid)
         lastXfer <= xferAddr;
   end
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bits
   task automatic sock(input logic [15:0] code, input logic [15:0] conn, input logic [15:0] opt,
      input logic [15:0] svc, input logic [31:0] a, input logic [15:0] p, input logic ok,
      input logic [15:0] exp);
      int k;
      @(negedge clk_sys);
      cmdCode = code;
      connNum = conn;
      optionBits = opt;
      service = svc;
      remoteAddr = a;
      remotePort = p;
      connOk = ok;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      for (k = 0; k < 400 && done !== 1'b1; k++)
         @(negedge clk_sys);
      chk_word(done ? errWord : ~exp, exp);
   endtask : sock
   task automatic do_reset();
      nrst = 1'b0;
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
   endtask : do_reset
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   initial
   begin
      #3000000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      {nrst, start, cmdCode, connNum, optionBits, service, remoteAddr, remotePort, connOk} = '0;
      {postDone, paramsLoaded, carrierSense, txSending, collisionSeen, linkPulseSeen} = '0;
      {polarityReversed, rxBitRaw, serRxActive, serTxActive, redirectWe, redirectSel} = '0;
      {redirectOn, serCmdValid, localRespValid, netRespValid, tcpLost, tcpLostIdx} = '0;
      {clientReady, serverReady} = '0;
      do_reset();
      chk_bits(activeIndicator, 32'h0);
      sock(16'h0005, CONN_FIRST, 16'h0, SVC_UDP, A, PORT_PEER, 1, ERR_BAD_CODE);
      sock(CODE_CREATE, 16'h4B14, 16'h0, SVC_UDP, A, PORT_PEER, 1, ERR_BAD_CONN);
      sock(CODE_CREATE, 16'h4B1D, 16'h0, SVC_UDP, A, PORT_PEER, 1, ERR_BAD_CONN);
      sock(CODE_CREATE, CONN_FIRST, 16'h0, 16'h0003, A, PORT_PEER, 1, ERR_BAD_SERVICE);
      sock(CODE_CREATE, CONN_FIRST, 16'h2, SVC_TCP, A, PORT_PEER, 1, ERR_OPT_CONFLICT);
      sock(CODE_CREATE, CONN_FIRST, 16'h0, SVC_UDP, 32'h0, PORT_PEER, 1, ERR_BAD_ADDR);
      sock(CODE_CREATE, CONN_FIRST, 16'h0, SVC_UDP, 32'hE000_0000, PORT_PEER, 1, ERR_BAD_ADDR);
      sock(CODE_CREATE, CONN_FIRST, 16'h2, SVC_UDP, A, 16'h0, 1, ERR_BAD_PORT);
      sock(CODE_CREATE, CONN_FIRST, 16'h0, SVC_UDP, ADDR_MAX, PORT_PEER, 1, ERR_NONE);
      sock(CODE_CREATE, CONN_FIRST, 16'h0, SVC_UDP, A, PORT_PEER, 1, ERR_CONN_IN_USE);
      sock(CODE_CREATE, 16'h4B16, 16'h0, SVC_TCP, A, PORT_PEER, 0, ERR_CONNECT_FAIL);
      sock(CODE_CREATE, 16'h4B16, 16'h0, SVC_TCP, A, PORT_PEER, 1, ERR_NONE);
      chk_bits(tcpConnAddr, A);
      chk_bits({tcpConnIdx, tcpConnPort}, 32'h105E1);
      sock(CODE_CREATE, 16'h4B17, 16'h2, SVC_UDP, A, PORT_PEER, 1, ERR_NONE);
      sock(CODE_CREATE, 16'h4B18, 16'h1, SVC_UDP, A, PORT_PEER, 1, ERR_NONE);
      for (i = 4; i < 8; i++)
         sock(CODE_CREATE, 16'(CONN_FIRST + i), 16'h0, SVC_UDP, A, PORT_PEER, 1, ERR_NONE);
      chk_bits(clientOpen, 32'hFF);
      sock(CODE_WRITE_REMOTE, CONN_FIRST, 16'h0, 16'h0, 32'h0A00_0009, 16'h1234, 1, ERR_NONE);
      chk_bits(lastXfer, ADDR_MAX);
      sock(CODE_READ_REMOTE, 16'h4B17, 16'h0, 16'h0, 32'h0A00_0009, 16'h1234, 1, ERR_NONE);
      chk_bits(lastXfer, 32'h0A00_0009);
      chk_bits({xferIdx, xferPort}, 32'h21234);
      clientReady = 8'h0B;
      serverReady = 1'b1;
      #1 chk_bits({schedValid, schedServer, schedClient}, 32'h13);
      clientReady = 8'h01;
      #1 chk_bits({schedValid, schedServer}, 32'h3);
      {clientReady, serverReady} = '0;
      $display("socket creation and scheduling finished");
      @(negedge clk_sys);
      tcpLostIdx = 3'h1;
      tcpLost = 1'b1;
      @(negedge clk_sys);
      tcpLost = 1'b0;
      sock(CODE_WRITE_REMOTE, 16'h4B16, 16'h0, 16'h0, A, PORT_PEER, 1, ERR_NOT_CONNECTED);
      sock(CODE_WRITE_REMOTE, 16'h4B16, 16'h0, 16'h0, A, PORT_PEER, 1, ERR_NOT_ACTIVE);
      chk_bits(clientOpen, 32'hFD);
      sock(CODE_CREATE, 16'h4B16, 16'h0, SVC_TCP, A, PORT_PEER, 1, ERR_NONE);
      $display("lost connection handling finished");
      postDone = 1'b1;
      repeat (3) @(negedge clk_sys);
      v = activeIndicator;
      repeat (4) @(negedge clk_sys);
      chk_bits(activeIndicator, {31'h0, ~v});
      paramsLoaded = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_bits(activeIndicator, 32'h1);
      repeat (5) @(negedge clk_sys);
      chk_bits(activeIndicator, 32'h1);
      {carrierSense, txSending, collisionSeen} = 3'b111;
      @(negedge clk_sys);
      {carrierSense, txSending, collisionSeen} = 3'b000;
      @(negedge clk_sys);
      chk_bits({receiveActivityIndicator, transmitActivityIndicator, collisionIndicator}, 32'h7);
      repeat (STR + 4) @(negedge clk_sys);
      chk_bits({receiveActivityIndicator, transmitActivityIndicator, collisionIndicator}, 32'h0);
      {linkPulseSeen, polarityReversed, rxBitRaw, serRxActive, serTxActive} = 7'b1110110;
      repeat (2) @(negedge clk_sys);
      chk_bits({linkPulseIndicator, auiIndicator, reversedPolarityIndicator, rxBitCorrected}, 32'hA);
      chk_bits({serRxIndicator, serTxIndicator}, 32'h6);
      {linkPulseSeen, rxBitRaw} = 2'b00;
      repeat (2) @(negedge clk_sys);
      chk_bits({linkPulseIndicator, auiIndicator, reversedPolarityIndicator, rxBitCorrected}, 32'h7);
      {redirectSel, redirectOn, redirectWe} = 4'b1011;
      @(negedge clk_sys);
      redirectWe = 1'b0;
      {serCmdValid, localRespValid, netRespValid} = 6'b110110;
      @(negedge clk_sys);
      chk_bits({redirected, localCmdValid, netFwdValid, serRespValid}, 32'h9B);
      do_reset();
      chk_bits({redirected, localCmdValid, netFwdValid}, 32'hC);
      chk_bits(clientOpen, 32'h0);
      $display("indicator and redirection tests finished");
      finish_test();
   end
endmodule : plc_socket_command_block_bench
`default_nettype wire
